// File: cgc_clock_generator_control.sv
// clock generator control: slow clock config, main oscillator, pll, usb pll
// assumes an avalon-mm master; analog oscillators and plls sit on the outputs
`timescale 1ns/10ps
module cgc_clock_generator_control import cgc_pkg::*; (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // slow clock controls
   output logic o_rc_osc_enable,
   output logic o_slow_xtal_enable,
   output logic o_slow_xtal_bypass,
   output logic o_slow_source_select,
   // main oscillator controls
   output logic o_main_xtal_enable,
   output logic o_main_xtal_bypass,
   output logic o_main_xtal_stable,
   // pll controls
   output logic [PLL_DIV_W-1:0] o_pll_divider,
   output logic [PLL_MUL_W-1:0] o_pll_multiplier,
   output logic o_pll_input_run,
   output logic o_pll_power,
   output logic o_pll_locked,
   // usb pll controls
   output logic o_usb_pll_enable,
   output logic o_usb_bias_enable,
   output logic o_usb_pll_locked,
   // requests: {usb, pll, main}
   output logic [2:0] o_irq_request
);
   typedef struct packed {
      logic waitreq; // bus stall, high unless answering
      logic [31:0] rdata; // read data held for the answer cycle
      logic rc_en;
      logic sx_en;
      logic sx_byp;
      logic sel; // selector as written
      logic [SEL_SYNC_TICKS-1:0] sel_pipe; // selector walked on slow ticks
      logic main_en;
      logic main_byp;
      logic [MAIN_CNT_W-1:0] main_cnt;
      logic main_flag;
      logic [PLL_DIV_W-1:0] div;
      logic [PLL_MUL_W-1:0] mul;
      logic [PLL_CNT_W-1:0] pll_cnt;
      logic pll_run;
      logic pll_pwr;
      logic pll_flag;
      logic usb_en;
      logic usb_bias;
      logic [USB_CNT_W-1:0] usb_cnt;
      logic usb_flag;
      logic [2:0] mask; // {usb, pll, main}
      logic [2:0] irq;
   } cgc_state_s;
   cgc_state_s st;
   cgc_state_s next_st;

   // tick enables and counters
   logic slow_tick;
   logic slow8_tick;
   logic main_load, main_stop, main_done;
   logic pll_load, pll_stop, pll_done;
   logic usb_load, usb_stop, usb_done;
   logic [31:0] rd_word; // current word at the bus address
   logic [31:0] wr_word; // written word merged by byte enables
   logic wr_take; // write takes effect at this edge

   // byte-lane merge of write data into the old word
   function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_w[8*i +: 8];
         end
      end
      return r;
   endfunction

   cgc_tick_gen u_ticks (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .o_slow_tick(slow_tick),
      .o_slow8_tick(slow8_tick)
   );

   // main startup count on slow clock divided by 8
   cgc_down_counter u_main_cnt (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_load(main_load),
      .i_stop(main_stop),
      .i_value(8'(wr_word[MAIN_CNT_LSB +: MAIN_CNT_W])),
      .i_tick(slow8_tick), // R07
      .o_busy(),
      .o_done(main_done)
   );

   // pll lock count on every slow tick
   cgc_down_counter u_pll_cnt (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_load(pll_load),
      .i_stop(pll_stop),
      .i_value(8'(wr_word[PLL_CNT_LSB +: PLL_CNT_W])),
      .i_tick(slow_tick), // R15
      .o_busy(),
      .o_done(pll_done)
   );

   // usb pll lock count on slow clock divided by 8
   cgc_down_counter u_usb_cnt (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_load(usb_load),
      .i_stop(usb_stop),
      .i_value(8'(wr_word[USB_CNT_LSB +: USB_CNT_W])),
      .i_tick(slow8_tick), // R18
      .o_busy(),
      .o_done(usb_done)
   );

   // read mux, unmapped reads as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (i_address)
         SLOW_CFG_ADDR: begin
            rd_word[RC_EN_BIT] = st.rc_en;
            rd_word[SX_EN_BIT] = st.sx_en;
            rd_word[SX_BYP_BIT] = st.sx_byp;
            rd_word[SEL_BIT] = st.sel;
         end
         MAIN_ADDR: begin
            rd_word[MAIN_EN_BIT] = st.main_en;
            rd_word[MAIN_BYP_BIT] = st.main_byp;
            rd_word[MAIN_CNT_LSB +: MAIN_CNT_W] = st.main_cnt;
         end
         PLL_ADDR: begin
            rd_word[PLL_DIV_LSB +: PLL_DIV_W] = st.div;
            rd_word[PLL_CNT_LSB +: PLL_CNT_W] = st.pll_cnt;
            rd_word[PLL_MUL_LSB +: PLL_MUL_W] = st.mul;
         end
         USB_ADDR: begin
            rd_word[USB_EN_BIT] = st.usb_en;
            rd_word[USB_CNT_LSB +: USB_CNT_W] = st.usb_cnt;
            rd_word[USB_BIAS_BIT] = st.usb_bias;
            // read-only factor, the usb pll cannot be reprogrammed
            rd_word[USB_FACTOR_LSB +: USB_FACTOR_W] = USB_PLL_FACTOR; // R16
         end
         STATUS_ADDR: begin
            rd_word[ST_MAIN_BIT] = st.main_flag;
            rd_word[ST_PLL_BIT] = st.pll_flag;
            rd_word[ST_USB_BIT] = st.usb_flag;
         end
         MASK_ADDR: begin
            rd_word[ST_MAIN_BIT] = st.mask[0];
            rd_word[ST_PLL_BIT] = st.mask[1];
            rd_word[ST_USB_BIT] = st.mask[2];
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   assign wr_word = merge_be(rd_word, i_writedata, i_byteenable);
   assign wr_take = i_write && !st.waitreq;

   // counter commands from writes; the write aborts the count in progress, at the pll only when divider or multiplier changes
   always_comb begin
      main_load = wr_take && (i_address == MAIN_ADDR) && wr_word[MAIN_EN_BIT]; // R07
      main_stop = wr_take && (i_address == MAIN_ADDR) && !wr_word[MAIN_EN_BIT]; // R06
      pll_load = 1'b0;
      pll_stop = 1'b0;
      if (wr_take && (i_address == PLL_ADDR) &&
          ((wr_word[PLL_DIV_LSB +: PLL_DIV_W] != st.div) ||
           (wr_word[PLL_MUL_LSB +: PLL_MUL_W] != st.mul))) begin
         // a zero multiplier means powered down, nothing to lock
         pll_load = (wr_word[PLL_MUL_LSB +: PLL_MUL_W] != '0); // R14
         pll_stop = !pll_load; // R13
      end
      usb_load = wr_take && (i_address == USB_ADDR) && wr_word[USB_EN_BIT]; // R17
      usb_stop = wr_take && (i_address == USB_ADDR) && !wr_word[USB_EN_BIT];
   end

   // next state: bus answer, register writes, flags, resync
   always_comb begin
      next_st = st;
      // one stall cycle, then answer
      next_st.waitreq = !((i_read || i_write) && st.waitreq);
      if ((i_read || i_write) && st.waitreq) begin
         next_st.rdata = i_read ? rd_word : 32'h0000_0000;
      end
      if (wr_take) begin
         unique case (i_address)
            SLOW_CFG_ADDR: begin
               next_st.rc_en = wr_word[RC_EN_BIT]; // R02
               next_st.sx_en = wr_word[SX_EN_BIT]; // R02
               next_st.sx_byp = wr_word[SX_BYP_BIT]; // R03
               next_st.sel = wr_word[SEL_BIT]; // R04
            end
            MAIN_ADDR: begin
               next_st.main_en = wr_word[MAIN_EN_BIT];
               next_st.main_byp = wr_word[MAIN_BYP_BIT];
               next_st.main_cnt = wr_word[MAIN_CNT_LSB +: MAIN_CNT_W];
            end
            PLL_ADDR: begin
               // divider 1..255 divides, 0 stops the input clock
               next_st.div = wr_word[PLL_DIV_LSB +: PLL_DIV_W]; // R10
               next_st.mul = wr_word[PLL_MUL_LSB +: PLL_MUL_W]; // R12
               next_st.pll_cnt = wr_word[PLL_CNT_LSB +: PLL_CNT_W];
            end
            USB_ADDR: begin
               next_st.usb_en = wr_word[USB_EN_BIT];
               next_st.usb_bias = wr_word[USB_BIAS_BIT];
               next_st.usb_cnt = wr_word[USB_CNT_LSB +: USB_CNT_W];
            end
            MASK_ADDR: begin
               next_st.mask = {wr_word[ST_USB_BIT], wr_word[ST_PLL_BIT],
                               wr_word[ST_MAIN_BIT]};
            end
            default: begin
               next_st.mask = st.mask; // status and unmapped: writes ignored
            end
         endcase
      end
      // flags: the clearing write restarts or stops the count, so it wins
      if (main_load || main_stop) begin
         next_st.main_flag = 1'b0; // R06
      end else if (main_done) begin
         next_st.main_flag = 1'b1; // R08
      end
      if (pll_load || pll_stop) begin
         next_st.pll_flag = 1'b0; // R14
      end else if (pll_done) begin
         next_st.pll_flag = 1'b1; // R15
      end
      if (usb_load || usb_stop) begin
         next_st.usb_flag = 1'b0; // R17
      end else if (usb_done) begin
         next_st.usb_flag = 1'b1; // R18
      end
      // selector walks through flops on slow ticks to switch cleanly
      if (slow_tick) begin
         next_st.sel_pipe = {st.sel_pipe[SEL_SYNC_TICKS-2:0], st.sel}; // R21
      end
      next_st.pll_run = (next_st.div != '0); // R11
      next_st.pll_pwr = (next_st.mul != '0); // R13
      next_st.irq = {next_st.usb_flag, next_st.pll_flag, next_st.main_flag} &
                    next_st.mask; // R20
   end

   // state register; main oscillator held off, rc selected
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         st <= '0; // R05
         st.waitreq <= 1'b1;
         st.rc_en <= RC_EN_RST; // R19
         st.sx_en <= SX_EN_RST;
         st.sx_byp <= SX_BYP_RST;
         st.sel <= SEL_RST;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign o_readdata = st.rdata;
   assign o_waitrequest = st.waitreq;
   assign o_rc_osc_enable = st.rc_en;
   assign o_slow_xtal_enable = st.sx_en;
   assign o_slow_xtal_bypass = st.sx_byp;
   assign o_slow_source_select = st.sel_pipe[SEL_SYNC_TICKS-1];
   assign o_main_xtal_enable = st.main_en;
   assign o_main_xtal_bypass = st.main_byp;
   assign o_main_xtal_stable = st.main_flag;
   assign o_pll_divider = st.div;
   assign o_pll_multiplier = st.mul;
   assign o_pll_input_run = st.pll_run;
   assign o_pll_power = st.pll_pwr;
   assign o_pll_locked = st.pll_flag;
   assign o_usb_pll_enable = st.usb_en;
   assign o_usb_bias_enable = st.usb_bias;
   assign o_usb_pll_locked = st.usb_flag;
   assign o_irq_request = st.irq;

   // checks
   sequence s_main_on;
      wr_take && (i_address == MAIN_ADDR) && wr_word[MAIN_EN_BIT];
   endsequence
   sequence s_main_off;
      wr_take && (i_address == MAIN_ADDR) && !wr_word[MAIN_EN_BIT];
   endsequence
   sequence s_usb_on;
      wr_take && (i_address == USB_ADDR) && wr_word[USB_EN_BIT];
   endsequence

   property p_reset_start;
      @(posedge i_clock) $fell(i_srst) |->
         o_rc_osc_enable && !o_slow_xtal_enable && !o_slow_source_select && !o_main_xtal_enable;
   endproperty
   a_reset_start: assert property (p_reset_start) else $error("bad reset state"); // R19

   property p_main_off;
      @(posedge i_clock) disable iff (i_srst) s_main_off |=> !o_main_xtal_stable[*2];
   endproperty
   a_main_off: assert property (p_main_off) else $error("stable flag kept on disable"); // R06

   property p_main_on;
      @(posedge i_clock) disable iff (i_srst) s_main_on |=> !o_main_xtal_stable && o_main_xtal_enable;
   endproperty
   a_main_on: assert property (p_main_on) else $error("stable flag not cleared"); // R07

   property p_main_done;
      @(posedge i_clock) disable iff (i_srst) main_done && !main_load && !main_stop |=> o_main_xtal_stable;
   endproperty
   a_main_done: assert property (p_main_done) else $error("stable flag not set"); // R08

   property p_pll_change;
      @(posedge i_clock) disable iff (i_srst) (pll_load || pll_stop) |=> !o_pll_locked;
   endproperty
   a_pll_change: assert property (p_pll_change) else $error("lock kept after change"); // R14

   property p_pll_tick;
      @(posedge i_clock) disable iff (i_srst) $rose(o_pll_locked) |-> $past(slow_tick);
   endproperty
   a_pll_tick: assert property (p_pll_tick) else $error("lock set off slow tick"); // R15

   property p_div_zero;
      @(posedge i_clock) disable iff (i_srst) (o_pll_divider == '0) |-> !o_pll_input_run;
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("pll runs with divider zero"); // R11

   property p_mul_zero;
      @(posedge i_clock) disable iff (i_srst) o_pll_power |-> (o_pll_multiplier != '0);
   endproperty
   a_mul_zero: assert property (p_mul_zero) else $error("pll powered with zero mul"); // R13

   property p_usb_on;
      @(posedge i_clock) disable iff (i_srst) s_usb_on |=> !o_usb_pll_locked && o_usb_pll_enable;
   endproperty
   a_usb_on: assert property (p_usb_on) else $error("usb lock not cleared"); // R17

   property p_irq;
      @(posedge i_clock) disable iff (i_srst)
         o_irq_request == ({o_usb_pll_locked, o_pll_locked, o_main_xtal_stable} & st.mask);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without flag"); // R20

   property p_sel_sync;
      @(posedge i_clock) disable iff (i_srst) $changed(o_slow_source_select) |-> $past(slow_tick);
   endproperty
   a_sel_sync: assert property (p_sel_sync) else $error("selector changed off tick"); // R21
endmodule // cgc_clock_generator_control

// File: cgc_down_counter.sv
// loadable down-counter stepping on a tick enable, reports reaching zero
// assumes load and stop never come with a stale count the caller still wants
`timescale 1ns/10ps
module cgc_down_counter (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // control
   input wire logic i_load,
   input wire logic i_stop,
   input wire logic [7:0] i_value,
   input wire logic i_tick,
   // status
   output logic o_busy,
   output logic o_done
);
   typedef struct packed {
      logic [7:0] count;
      logic busy;
   } cgc_cnt_s;
   cgc_cnt_s st;
   cgc_cnt_s next_st;

   // done does not look at load or stop, so the caller can merge them freely
   assign o_done = st.busy && i_tick && (st.count <= 8'h01);
   assign o_busy = st.busy;

   // next count
   always_comb begin
      next_st = st;
      if (i_load) begin
         next_st.count = i_value;
         next_st.busy = 1'b1;
      end else if (i_stop) begin
         next_st.busy = 1'b0;
      end else if (o_done) begin
         next_st.count = 8'h00;
         next_st.busy = 1'b0;
      end else if (st.busy && i_tick) begin
         next_st.count = st.count - 8'h01;
      end
   end

   // state register
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule // cgc_down_counter

// File: cgc_osc_model.sv
// behavioural model of the slow oscillators and the pll behind the control block
// assumes the enables come straight from the block's registered outputs
`timescale 1ns/10ps
module cgc_osc_model import cgc_pkg::*; (
   // system clock, used only to time the model
   input wire logic i_clock,
   // slow source controls
   input wire logic i_rc_osc_enable,
   input wire logic i_slow_xtal_enable,
   input wire logic i_slow_xtal_bypass,
   input wire logic i_slow_source_select,
   // pll controls
   input wire logic i_pll_input_run,
   input wire logic i_pll_power,
   // modelled clocks
   output logic o_slow_clock,
   output logic o_pll_clock
);
   int half_cnt = 0; // half period of the slow clock in system cycles
   logic src_run; // selected source is alive
   logic slow_q = 1'b0; // slow clock level, one driver only
   logic pll_q = 1'b0; // pll clock level, one driver only
   // rc for select 0, crystal or external pin for select 1
   assign src_run = i_slow_source_select ? (i_slow_xtal_enable | i_slow_xtal_bypass)
      : i_rc_osc_enable;
   // a dead source gives a flat clock, never the last level held by chance
   always @(posedge i_clock) begin
      half_cnt <= (half_cnt >= SLOW_TICK_CYCLES / 2) ? 0 : half_cnt + 1;
      if (!src_run) begin
         slow_q <= 1'b0;
      end else if (half_cnt == 0) begin
         slow_q <= !slow_q;
      end
      // divider zero or multiplier zero holds the pll output low
      pll_q <= (i_pll_input_run && i_pll_power) ? !pll_q : 1'b0;
   end
   assign o_slow_clock = slow_q;
   assign o_pll_clock = pll_q;
endmodule // cgc_osc_model

// File: cgc_pkg.sv
// constants for the clock generator control block: offsets, fields, resets, timing
// assumes a 20 MHz system clock and an avalon-mm master on the register side
// Behaviour
// R01: software waits resync ticks before killing crystal
// R02: two enable bits switch rc and crystal
// R03: bypass bit takes external clock on pin
// R04: selector bit: 0 rc, 1 crystal
// R05: main oscillator off after reset
// R06: main disable clears stable flag
// R07: main enable loads startup count, div8 ticks
// R08: startup count zero sets stable flag
// R09: software sets bypass with enable off
// R10: pll divider accepts 1 to 255
// R11: divider zero holds divider and pll low
// R12: pll output is source times mul+1 over div
// R13: multiplier zero powers pll down
// R14: pll change clears lock, loads lock count
// R15: lock count decrements per slow tick, sets lock
// R16: usb pll factor fixed at forty
// R17: usb enable clears usb lock, bias same write
// R18: usb lock count on div8 ticks sets lock
// R19: reset: rc on, crystal off, selector rc
// R20: irq request only while flag and mask set
// R21: selector change resynchronised on slow ticks
package cgc_pkg;
   // register byte addresses
   localparam int ADDR_W = 28;
   localparam logic [ADDR_W-1:0] SLOW_CFG_ADDR = 28'hFFFFD50;
   localparam logic [ADDR_W-1:0] MAIN_ADDR = 28'hFFFFC20;
   localparam logic [ADDR_W-1:0] PLL_ADDR = 28'hFFFFC28;
   localparam logic [ADDR_W-1:0] USB_ADDR = 28'hFFFFC1C;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 28'hFFFFC68;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 28'hFFFFC6C;
   // slow_clock_config fields
   localparam int RC_EN_BIT = 0;
   localparam int SX_EN_BIT = 1;
   localparam int SX_BYP_BIT = 2;
   localparam int SEL_BIT = 3;
   // main_xtal_register fields
   localparam int MAIN_EN_BIT = 0;
   localparam int MAIN_BYP_BIT = 1;
   localparam int MAIN_CNT_LSB = 8;
   localparam int MAIN_CNT_W = 8;
   // pll_config_register fields
   localparam int PLL_DIV_LSB = 0;
   localparam int PLL_DIV_W = 8;
   localparam int PLL_CNT_LSB = 8;
   localparam int PLL_CNT_W = 6;
   localparam int PLL_MUL_LSB = 16;
   localparam int PLL_MUL_W = 11;
   // usb_clock_register fields
   localparam int USB_EN_BIT = 16;
   localparam int USB_CNT_LSB = 20;
   localparam int USB_CNT_W = 4;
   localparam int USB_BIAS_BIT = 24;
   localparam int USB_FACTOR_LSB = 26;
   localparam int USB_FACTOR_W = 6;
   localparam logic [USB_FACTOR_W-1:0] USB_PLL_FACTOR = 6'h28;
   // status and mask bit positions
   localparam int ST_MAIN_BIT = 0;
   localparam int ST_PLL_BIT = 1;
   localparam int ST_USB_BIT = 6;
   // reset values of slow_clock_config
   localparam logic RC_EN_RST = 1'b1;
   localparam logic SX_EN_RST = 1'b0;
   localparam logic SX_BYP_RST = 1'b0;
   localparam logic SEL_RST = 1'b0;
   // timing
   localparam int CLOCK_HZ = 20000000;
   localparam int SLOW_HZ = 32768;
   localparam int SLOW_TICK_CYCLES = CLOCK_HZ / SLOW_HZ;
   localparam int CYC_W = $clog2(SLOW_TICK_CYCLES);
   localparam int SLOW_DIV8 = 8;
   localparam int SEL_SYNC_TICKS = 2;
endpackage : cgc_pkg

// File: cgc_tick_gen.sv
// slow clock tick and slow clock divided by 8 tick, as one-cycle enables
// assumes the system clock rate given in the package
`timescale 1ns/10ps
module cgc_tick_gen import cgc_pkg::*; (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // ticks
   output logic o_slow_tick,
   output logic o_slow8_tick
);
   typedef struct packed {
      logic [CYC_W-1:0] cyc; // system cycles within a slow period
      logic [2:0] oct; // slow ticks within a div8 period
      logic slow;
      logic slow8;
   } cgc_tick_s;
   cgc_tick_s st;
   cgc_tick_s next_st;

   // next tick state
   always_comb begin
      next_st = st;
      next_st.slow = 1'b0;
      next_st.slow8 = 1'b0;
      if (st.cyc == CYC_W'(SLOW_TICK_CYCLES - 1)) begin
         next_st.cyc = '0;
         next_st.slow = 1'b1;
         next_st.oct = st.oct + 3'h1;
         // wraps after SLOW_DIV8 ticks
         next_st.slow8 = (st.oct == 3'(SLOW_DIV8 - 1));
      end else begin
         next_st.cyc = st.cyc + CYC_W'(1);
      end
   end

   // state register
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_slow_tick = st.slow;
   assign o_slow8_tick = st.slow8;
endmodule // cgc_tick_gen

// File: tb_clock_generator_control.sv
// self-checking bench for the clock generator control block
// assumes the one-wait avalon answer and the tick rates of the package
`timescale 1ns/10ps
module tb_clock_generator_control;
   import cgc_pkg::*;
   logic i_clock, i_srst, i_read, i_write; // bench driven
   logic [ADDR_W-1:0] i_address;
   logic [31:0] i_writedata, o_readdata, q;
   logic [3:0] i_byteenable;
   logic o_waitrequest, rc, sx, byp, sel, men, mbyp, mst, prun, ppow, plk, uen, ubias, ulk;
   logic slow_clk, pll_clk;
   logic [7:0] pdiv;
   logic [10:0] pmul;
   logic [2:0] irq;
   int err_total = 0;
   int tests_run = 0;
   int n;
   cgc_clock_generator_control dut (.i_clock(i_clock), .i_srst(i_srst),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .o_rc_osc_enable(rc), .o_slow_xtal_enable(sx),
      .o_slow_xtal_bypass(byp), .o_slow_source_select(sel), .o_main_xtal_enable(men),
      .o_main_xtal_bypass(mbyp), .o_main_xtal_stable(mst), .o_pll_divider(pdiv),
      .o_pll_multiplier(pmul), .o_pll_input_run(prun), .o_pll_power(ppow),
      .o_pll_locked(plk), .o_usb_pll_enable(uen), .o_usb_bias_enable(ubias),
      .o_usb_pll_locked(ulk), .o_irq_request(irq));
   cgc_osc_model osc (.i_clock(i_clock), .i_rc_osc_enable(rc), .i_slow_xtal_enable(sx),
      .i_slow_xtal_bypass(byp), .i_slow_source_select(sel), .i_pll_input_run(prun),
      .i_pll_power(ppow), .o_slow_clock(slow_clk), .o_pll_clock(pll_clk));
   // 50 ns clock
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = !i_clock;
   end
   // one comparison, counted
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
      input logic [3:0] b);
      int k;
      k = 0;
      @(posedge i_clock);
      i_address <= a;
      i_writedata <= d;
      i_byteenable <= b;
      i_read <= !w;
      i_write <= w;
      do begin
         @(posedge i_clock);
         k++;
      end while (o_waitrequest !== 1'b0 && k < 50);
      q = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      if (k >= 50) err_total++;
      // let the answer edge land before outputs are judged
      @(negedge i_clock);
   endtask
   // wait on a flag under a bound, count the cycles spent
   task automatic wait_bit(input int which, input int limit);
      logic v;
      n = 0;
      do begin
         @(negedge i_clock);
         n++;
         case (which)
            0: v = sel;
            1: v = mst;
            2: v = plk;
            default: v = ulk;
         endcase
      end while (v !== 1'b1 && n < limit);
      check(v, 1'b1);
   endtask
   // reset state and slow clock config
   task automatic t_slow;
      logic b; // slow clock level before the wait
      bus(0, SLOW_CFG_ADDR, 0, 4'hF);
      check(q, 32'h1);
      check({men, mst, prun, ppow}, 0);
      bus(1, SLOW_CFG_ADDR, 32'hE, 4'h0);
      check(rc, 1'b1);
      bus(1, SLOW_CFG_ADDR, 32'hE, 4'hF);
      check({rc, sx, byp, sel}, 4'h6);
      wait_bit(0, 3 * SLOW_TICK_CYCLES + 20);
      bus(0, SLOW_CFG_ADDR, 0, 4'hF);
      check(q, 32'hE);
      // back to rc: rc on, settle, clear selector, 5 slow cycles, crystal off
      bus(1, SLOW_CFG_ADDR, 32'hF, 4'hF);
      repeat (SLOW_TICK_CYCLES) @(posedge i_clock);
      bus(1, SLOW_CFG_ADDR, 32'h7, 4'hF);
      repeat (5 * SLOW_TICK_CYCLES) @(posedge i_clock);
      check(sel, 1'b0);
      bus(1, SLOW_CFG_ADDR, 32'h1, 4'hF);
      check({rc, sx, byp, sel}, 4'h8);
      // the model must run again from the rc source
      n = 0;
      b = slow_clk;
      while (slow_clk === b && n < SLOW_TICK_CYCLES) begin
         @(posedge i_clock);
         n++;
      end
      check(slow_clk, !b);
      $display("slow clock config done");
   endtask
   // main oscillator startup count and its request
   task automatic t_main;
      bus(1, MASK_ADDR, 32'h43, 4'hF);
      bus(1, MAIN_ADDR, 32'h0201, 4'hF);
      check({men, mst, irq[0]}, 3'h4);
      wait_bit(1, 3 * SLOW_TICK_CYCLES * SLOW_DIV8);
      check(n > SLOW_TICK_CYCLES * SLOW_DIV8, 1'b1);
      check(irq[0], 1'b1);
      bus(1, MAIN_ADDR, 32'h2, 4'hF);
      check({men, mbyp, mst, irq[0]}, 4'h4);
      $display("main oscillator done");
   endtask
   // pll lock on slow ticks, restart and power down
   task automatic t_pll;
      bus(1, PLL_ADDR, 32'h00030201, 4'hF);
      check({pdiv, pmul, prun, ppow, plk}, {8'h1, 11'h3, 3'h6});
      wait_bit(2, 3 * SLOW_TICK_CYCLES + 20);
      check(n > SLOW_TICK_CYCLES, 1'b1);
      check(irq[1], 1'b1);
      bus(1, PLL_ADDR, 32'h000302FF, 4'hF);
      check({pdiv, plk}, {8'hFF, 1'b0});
      bus(1, PLL_ADDR, 32'h000002FF, 4'hF);
      check({ppow, plk, irq[1]}, 3'h0);
      bus(1, PLL_ADDR, 32'h00010200, 4'hF);
      check({prun, ppow}, 2'h1);
      @(negedge i_clock);
      check(pll_clk, 1'b0);
      $display("pll done");
   endtask
   // usb pll fixed factor, enable with bias, lock on div8 ticks
   task automatic t_usb;
      bus(0, USB_ADDR, 0, 4'hF);
      check(q[31:26], 6'h28);
      bus(1, USB_ADDR, 32'h01110000, 4'hF);
      check({uen, ubias, ulk}, 3'h6);
      wait_bit(3, 2 * SLOW_TICK_CYCLES * SLOW_DIV8 + 50);
      check(irq[2], 1'b1);
      bus(1, STATUS_ADDR, 0, 4'hF);
      bus(0, STATUS_ADDR, 0, 4'hF);
      check(q[ST_USB_BIT], 1'b1);
      bus(0, 28'h0000010, 0, 4'hF);
      check(q, 32'h0);
      $display("usb pll done");
   endtask
   // main sequence: reset for 4 cycles, then the scenarios
   initial begin
      i_srst = 1'b1;
      i_read = 1'b0;
      i_write = 1'b0;
      i_address = '0;
      i_writedata = '0;
      i_byteenable = 4'hF;
      repeat (4) @(posedge i_clock);
      i_srst <= 1'b0;
      t_slow();
      t_main();
      t_pll();
      t_usb();
      stop_test();
   end
   // watchdog well beyond the expected run of at most about 21500 cycles
   initial begin
      #(90000 * 50);
      err_total++;
      stop_test();
   end
endmodule // tb_clock_generator_control
